// ===== verilog/afcc_pkg.sv
// Register map, field layout, reset values and timing constants of the fan cruise block
package afcc_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [5:0] IDX_SYS_MIN = 6'h08;
  localparam logic [5:0] IDX_CPU_MIN = 6'h09;
  localparam logic [5:0] IDX_STEP_DOWN = 6'h0e;
  localparam logic [5:0] IDX_STEP_UP = 6'h0f;
  localparam logic [5:0] IDX_RSVD_10 = 6'h10;
  localparam logic [5:0] IDX_AUX_LEVEL = 6'h11;
  localparam logic [5:0] IDX_FAN_CFG2 = 6'h12;
  localparam logic [5:0] IDX_AUX_TARGET = 6'h13;
  localparam logic [5:0] IDX_AUX_TOL = 6'h14;
  localparam logic [5:0] IDX_AUX_STOP = 6'h15;
  localparam logic [5:0] IDX_AUX_START = 6'h16;
  localparam logic [5:0] IDX_AUX_STOP_TIME = 6'h17;
  localparam logic [5:0] IDX_VOVT_CFG = 6'h18;
  localparam logic [5:0] IDX_RSVD_19 = 6'h19;
  localparam logic [5:0] IDX_SCRATCH_A = 6'h1a;
  localparam logic [5:0] IDX_SCRATCH_B = 6'h1b;
  localparam logic [5:0] IDX_RSVD_LO = 6'h1c;
  localparam logic [5:0] IDX_RSVD_HI = 6'h1f;
  localparam logic [5:0] IDX_INT_STATUS = 6'h20;
  localparam logic [5:0] IDX_INT_MASK = 6'h21;
  localparam logic [5:0] IDX_FAN_STATUS = 6'h22;

  // Reset values
  localparam logic [7:0] RST_MIN_LEVEL = 8'h01;
  localparam logic [7:0] RST_STEP = 8'h0a;
  localparam logic [7:0] RST_AUX_LEVEL = 8'hff;
  localparam logic [7:0] RST_FAN_CFG2 = 8'h00;
  localparam logic [7:0] RST_AUX_TARGET = 8'h00;
  localparam logic [7:0] RST_AUX_TOL = 8'h00;
  localparam logic [7:0] RST_AUX_STOP = 8'h01;
  localparam logic [7:0] RST_AUX_START = 8'h01;
  localparam logic [7:0] RST_AUX_STOP_TIME = 8'h3c;
  localparam logic [7:0] RST_VOVT_CFG = 8'h43;
  localparam logic [7:0] RST_SCRATCH = 8'hff;
  localparam logic [2:0] RST_INT = 3'h0;

  // Field positions
  localparam int CFG2_SYS_HOLD = 5;
  localparam int CFG2_CPU_HOLD = 4;
  localparam int CFG2_AUX_HOLD = 3;
  localparam int CFG2_MODE_MSB = 2;
  localparam int CFG2_MODE_LSB = 1;
  localparam int LEVEL_MSB = 7;
  localparam int LEVEL_LSB = 4;
  localparam int TARGET_TEMP_MSB = 6;
  localparam int TOL_MSB = 3;
  localparam int VOVT_OVT_DIS = 6;
  localparam int VOVT_OVT_MODE = 4;
  localparam int VOVT_VSEL = 0;
  localparam int INT_OVT = 0;
  localparam int INT_AUX_START = 1;
  localparam int INT_AUX_STOP = 2;
  localparam int INT_W = 3;

  // Drive levels
  localparam logic [7:0] DRIVE_ZERO = 8'h00;
  localparam logic [7:0] DRIVE_MAX = 8'hff;
  localparam logic [3:0] LEVEL_PAD = 4'h0;

  // Timing: 0.1 s time base, ramp step unit of 1.6 s
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES_DFLT = CLK_HZ / 1000 * TICK_MS;
  localparam int STEP_UNIT_MS = 1600;
  localparam int STEP_TICKS = STEP_UNIT_MS / TICK_MS;

  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b00,
    MODE_TEMP = 2'b01,
    MODE_SPEED = 2'b10,
    MODE_NONE = 2'b11
  } afcc_mode_e;

  typedef enum logic [1:0] {
    AUX_OFF = 2'b00,
    AUX_RUN = 2'b01,
    AUX_STOP = 2'b11
  } afcc_aux_state_e;
endpackage

// ===== verilog/afcc_top.sv
// Fan cruise control registers and drive ramps behind an APB slave
// What this block does
// [RL1] Ramp drive up one step per step-up interval
// [RL2] Aux drive level from output register bits 7-4
// [RL3] System drive floors at its minimum when hold set
// [RL4] Processor drive floors at its minimum when hold set
// [RL5] Aux drive floors at stop value when hold set
// [RL6] Mode field picks manual, temperature or speed cruise
// [RL7] Target read as temperature or speed by mode
// [RL8] Tolerance band around the aux target
// [RL9] Temperature cruise lowers aux drive to stop value
// [RL10] Software should program a non-zero stop value
// [RL11] Aux start jumps from zero to start-up value
// [RL12] Stop time in 0.1 s units to zero
// [RL13] Disable bit silences the over-temperature alert
// [RL14] Alert mode: comparator or latched interrupt
// [RL15] Core voltage formula select output, reset one
// [RL16] Two scratch bytes, reset all ones
// [RL17] Ramp drive down one step per step-down interval
// [RL18] Reserved indices read zero, ignore writes
// [RL19] Timers run from tick, reload on write
module afcc_top
#(
  parameter int unsigned TICK_CYCLES = afcc_pkg::TICK_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sensor side inputs
  input wire logic [7:0] aux_temp_input,
  input wire logic [7:0] aux_tach_input,
  input wire logic system_temp_hot,
  input wire logic system_temp_cold,
  input wire logic processor_temp_hot,
  input wire logic processor_temp_cold,
  input wire logic system_temp_over,
  // Fan drives
  output logic [7:0] system_fan_drive,
  output logic [7:0] processor_fan_drive,
  output logic [7:0] aux_fan_drive,
  // Alert, formula select and interrupt
  output logic overtemp_alert_out_n,
  output logic core_volt_formula_sel,
  output logic irq
);
  import afcc_pkg::*;

  localparam int SYNC_W = 21;

  // Registers
  logic [7:0] sys_min_level;
  logic [7:0] cpu_min_level;
  logic [7:0] fan_step_down_time;
  logic [7:0] fan_step_up_time;
  logic [7:0] aux_fan_output_level;
  logic [7:0] fan_config_two;
  logic [7:0] aux_target_temp_or_speed;
  logic [7:0] aux_target_tolerance;
  logic [7:0] aux_fan_stop_value;
  logic [7:0] aux_fan_startup_value;
  logic [7:0] aux_fan_stop_time;
  logic [7:0] vcore_and_overtemp_config;
  logic [7:0] scratch_byte_a;
  logic [7:0] scratch_byte_b;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_mask;

  // Pin synchronisers; the multi-bit readings are slow sensor values, so a
  // torn sample lasts one cycle and only nudges a ramp decision
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic over_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {aux_temp_input, aux_tach_input, system_temp_hot, system_temp_cold,
                 processor_temp_hot, processor_temp_cold, system_temp_over};
      sync_b <= sync_a;
    end
  end

  wire [7:0] temp_meas = sync_b[20:13];
  wire [7:0] tach_meas = sync_b[12:5];
  wire [1:0] ch_hot = {sync_b[2], sync_b[4]};
  wire [1:0] ch_cold = {sync_b[1], sync_b[3]};
  wire over_now = sync_b[0];

  // APB decode
  wire [5:0] idx = paddr[7:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_sys_min = (idx == IDX_SYS_MIN);
  wire hit_cpu_min = (idx == IDX_CPU_MIN);
  wire hit_step_down = (idx == IDX_STEP_DOWN);
  wire hit_step_up = (idx == IDX_STEP_UP);
  wire hit_aux_level = (idx == IDX_AUX_LEVEL);
  wire hit_fan_cfg2 = (idx == IDX_FAN_CFG2);
  wire hit_aux_target = (idx == IDX_AUX_TARGET);
  wire hit_aux_tol = (idx == IDX_AUX_TOL);
  wire hit_aux_stop = (idx == IDX_AUX_STOP);
  wire hit_aux_start = (idx == IDX_AUX_START);
  wire hit_stop_time = (idx == IDX_AUX_STOP_TIME);
  wire hit_vovt = (idx == IDX_VOVT_CFG);
  wire hit_scratch_a = (idx == IDX_SCRATCH_A);
  wire hit_scratch_b = (idx == IDX_SCRATCH_B);
  wire hit_int_status = (idx == IDX_INT_STATUS);
  wire hit_int_mask = (idx == IDX_INT_MASK);
  wire hit_fan_status = (idx == IDX_FAN_STATUS);
  // [RL18] Reserved indices decode
  wire hit_rsvd = (idx == IDX_RSVD_10) || (idx == IDX_RSVD_19) ||
                  ((idx >= IDX_RSVD_LO) && (idx <= IDX_RSVD_HI));
  wire hit_span = (idx >= IDX_STEP_DOWN) && (idx <= IDX_FAN_STATUS);
  wire hit_any = hit_sys_min | hit_cpu_min | hit_span | hit_rsvd;
  wire mapped = aligned && hit_any;
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite && pready && mapped;
  wire [7:0] wd = pwdata[7:0];

  wire [7:0] rd_byte =
      hit_sys_min ? sys_min_level :
      hit_cpu_min ? cpu_min_level :
      hit_step_down ? fan_step_down_time :
      hit_step_up ? fan_step_up_time :
      hit_aux_level ? aux_fan_output_level :
      hit_fan_cfg2 ? fan_config_two :
      hit_aux_target ? aux_target_temp_or_speed :
      hit_aux_tol ? aux_target_tolerance :
      hit_aux_stop ? aux_fan_stop_value :
      hit_aux_start ? aux_fan_startup_value :
      hit_stop_time ? aux_fan_stop_time :
      hit_vovt ? vcore_and_overtemp_config :
      hit_scratch_a ? scratch_byte_a :
      hit_scratch_b ? scratch_byte_b :
      hit_int_status ? {5'h00, int_status} :
      hit_int_mask ? {5'h00, int_mask} :
      hit_fan_status ? aux_fan_drive : 8'h00;

  // Zero-wait slave: read data and error are prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        pslverr <= !mapped;
      end
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_min_level <= RST_MIN_LEVEL;
      cpu_min_level <= RST_MIN_LEVEL;
      fan_step_down_time <= RST_STEP;
      fan_step_up_time <= RST_STEP;
      aux_fan_output_level <= RST_AUX_LEVEL;
      fan_config_two <= RST_FAN_CFG2;
      aux_target_temp_or_speed <= RST_AUX_TARGET;
      aux_target_tolerance <= RST_AUX_TOL;
      aux_fan_stop_value <= RST_AUX_STOP;
      aux_fan_startup_value <= RST_AUX_START;
      aux_fan_stop_time <= RST_AUX_STOP_TIME;
      vcore_and_overtemp_config <= RST_VOVT_CFG;
      scratch_byte_a <= RST_SCRATCH;
      scratch_byte_b <= RST_SCRATCH;
      int_mask <= RST_INT;
    end else if (wr) begin
      if (hit_sys_min) sys_min_level <= wd;
      if (hit_cpu_min) cpu_min_level <= wd;
      if (hit_step_down) fan_step_down_time <= wd;
      if (hit_step_up) fan_step_up_time <= wd;
      if (hit_aux_level) aux_fan_output_level <= wd;
      if (hit_fan_cfg2) fan_config_two <= wd;
      if (hit_aux_target) aux_target_temp_or_speed <= wd;
      if (hit_aux_tol) aux_target_tolerance <= wd;
      if (hit_aux_stop) aux_fan_stop_value <= wd;
      if (hit_aux_start) aux_fan_startup_value <= wd;
      if (hit_stop_time) aux_fan_stop_time <= wd;
      if (hit_vovt) vcore_and_overtemp_config <= wd;
      // [RL16] Scratch bytes
      if (hit_scratch_a) scratch_byte_a <= wd;
      if (hit_scratch_b) scratch_byte_b <= wd;
      if (hit_int_mask) int_mask <= wd[INT_W-1:0];
    end
  end

  // [RL19] Time base and ramp interval timers
  logic [23:0] tick_cnt;
  logic [11:0] up_cnt;
  logic [11:0] down_cnt;
  wire tick = (tick_cnt == 24'(TICK_CYCLES - 1));
  wire [11:0] up_limit = 12'(fan_step_up_time * STEP_TICKS);
  wire [11:0] down_limit = 12'(fan_step_down_time * STEP_TICKS);
  // [RL1] Step-up pulse every programmed interval
  wire up_step = tick && ((up_cnt + 12'h001) >= up_limit);
  // [RL17] Step-down pulse every programmed interval
  wire down_step = tick && ((down_cnt + 12'h001) >= down_limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 24'h00_0000;
      up_cnt <= 12'h000;
      down_cnt <= 12'h000;
    end else begin
      tick_cnt <= tick ? 24'h00_0000 : tick_cnt + 24'h00_0001;
      if ((wr && hit_step_up) || up_step) up_cnt <= 12'h000;
      else if (tick) up_cnt <= up_cnt + 12'h001;
      if ((wr && hit_step_down) || down_step) down_cnt <= 12'h000;
      else if (tick) down_cnt <= down_cnt + 12'h001;
    end
  end

  // System and processor ramps: index 0 system, index 1 processor
  logic [7:0] ch_drive [2];
  wire [1:0] ch_hold = {fan_config_two[CFG2_CPU_HOLD], fan_config_two[CFG2_SYS_HOLD]};
  wire [7:0] ch_min [2];
  assign ch_min[0] = sys_min_level;
  assign ch_min[1] = cpu_min_level;

  for (genvar i = 0; i < 2; i++) begin : g_ramp
    // [RL3] [RL4] Floor is the minimum level with hold, else zero
    wire [7:0] floor_lvl = ch_hold[i] ? ch_min[i] : DRIVE_ZERO;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ch_drive[i] <= DRIVE_ZERO;
      end else if (ch_hot[i] && up_step && (ch_drive[i] != DRIVE_MAX)) begin
        ch_drive[i] <= ch_drive[i] + 8'h01;
      end else if (ch_cold[i] && down_step && (ch_drive[i] > floor_lvl)) begin
        ch_drive[i] <= ch_drive[i] - 8'h01;
      end
    end
  end

  assign system_fan_drive = ch_drive[0];
  assign processor_fan_drive = ch_drive[1];

  // Auxiliary fan cruise
  // [RL6] Mode field
  wire afcc_mode_e aux_mode = afcc_mode_e'(fan_config_two[CFG2_MODE_MSB:CFG2_MODE_LSB]);
  // [RL7] Target width follows the mode
  wire [7:0] target = (aux_mode == MODE_TEMP) ?
                      {1'b0, aux_target_temp_or_speed[TARGET_TEMP_MSB:0]} :
                      aux_target_temp_or_speed;
  // [RL8] Tolerance band
  wire [8:0] tol = {5'h00, aux_target_tolerance[TOL_MSB:0]};
  wire [8:0] meas = (aux_mode == MODE_TEMP) ? {1'b0, temp_meas} : {1'b0, tach_meas};
  wire above = meas > ({1'b0, target} + tol);
  wire below = (meas + tol) < {1'b0, target};
  // Hot temperature or slow tach both call for more drive
  wire aux_raise = (aux_mode == MODE_TEMP) ? above : below;
  wire aux_lower = (aux_mode == MODE_TEMP) ? below : above;
  wire aux_hold = fan_config_two[CFG2_AUX_HOLD];

  afcc_aux_state_e aux_state;
  afcc_aux_state_e next_aux_state;
  logic [7:0] next_aux_drive;
  logic [7:0] stop_cnt;
  logic [7:0] next_stop_cnt;
  logic aux_started;
  logic aux_stopped;

  always_comb begin
    next_aux_state = aux_state;
    next_aux_drive = aux_fan_drive;
    next_stop_cnt = stop_cnt;
    aux_started = 1'b0;
    aux_stopped = 1'b0;
    case (aux_mode)
      MODE_MANUAL: begin
        // [RL2] Top nibble scales the full-scale drive by sixteenths
        next_aux_state = AUX_OFF;
        next_aux_drive = {aux_fan_output_level[LEVEL_MSB:LEVEL_LSB], LEVEL_PAD};
      end
      MODE_TEMP, MODE_SPEED: begin
        case (aux_state)
          AUX_OFF: begin
            // [RL11] Start from zero at the start-up value
            if (aux_raise) begin
              next_aux_state = AUX_RUN;
              next_aux_drive = aux_fan_startup_value;
              aux_started = 1'b1;
            end
          end
          AUX_RUN: begin
            // [RL1] Raise one step
            if (aux_raise && up_step && (aux_fan_drive != DRIVE_MAX)) begin
              next_aux_drive = aux_fan_drive + 8'h01;
            // [RL17] Lower one step
            end else if (aux_lower && down_step) begin
              // [RL9] Descend no lower than the stop value
              if (aux_fan_drive > aux_fan_stop_value) begin
                next_aux_drive = aux_fan_drive - 8'h01;
              // [RL5] Hold at stop value
              end else if (aux_hold) begin
                next_aux_drive = aux_fan_stop_value;
              end else begin
                next_aux_drive = aux_fan_stop_value;
                next_aux_state = AUX_STOP;
                next_stop_cnt = aux_fan_stop_time;
              end
            end
          end
          AUX_STOP: begin
            // [RL12] Count stop time in ticks, then drop to zero
            if (aux_raise) begin
              next_aux_state = AUX_RUN;
            end else if (tick) begin
              if (stop_cnt <= 8'h01) begin
                next_aux_state = AUX_OFF;
                next_aux_drive = DRIVE_ZERO;
                aux_stopped = 1'b1;
              end else begin
                next_stop_cnt = stop_cnt - 8'h01;
              end
            end
          end
          default: begin
            next_aux_state = AUX_OFF;
            next_aux_drive = DRIVE_ZERO;
          end
        endcase
      end
      default: begin
        // Reserved mode freezes the aux drive where it stands
        next_aux_state = aux_state;
      end
    endcase
    // [RL19] Writing the stop time restarts the running count
    if (wr && hit_stop_time) begin
      next_stop_cnt = wd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_state <= AUX_OFF;
      aux_fan_drive <= DRIVE_ZERO;
      stop_cnt <= RST_AUX_STOP_TIME;
    end else begin
      aux_state <= next_aux_state;
      aux_fan_drive <= next_aux_drive;
      stop_cnt <= next_stop_cnt;
    end
  end

  // Over-temperature alert and interrupt status
  wire ovt_disabled = vcore_and_overtemp_config[VOVT_OVT_DIS];
  wire ovt_latched = vcore_and_overtemp_config[VOVT_OVT_MODE];
  wire ovt_rise = over_now && !over_prev && !ovt_disabled;
  wire [INT_W-1:0] int_set = {aux_stopped, aux_started, ovt_rise};
  wire [INT_W-1:0] int_clr = (wr && hit_int_status) ? wd[INT_W-1:0] : RST_INT;
  // Set wins over a same-cycle clear
  wire [INT_W-1:0] next_int_status = (int_status & ~int_clr) | int_set;
  // [RL14] Comparator follows the input, interrupt mode follows the latch
  wire ovt_active = ovt_latched ? next_int_status[INT_OVT] : over_now;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_prev <= 1'b0;
      int_status <= RST_INT;
      irq <= 1'b0;
      overtemp_alert_out_n <= 1'b1;
      core_volt_formula_sel <= RST_VOVT_CFG[VOVT_VSEL];
    end else begin
      over_prev <= over_now;
      int_status <= next_int_status;
      irq <= |(next_int_status & int_mask);
      // [RL13] Disable forces the alert inactive
      overtemp_alert_out_n <= !(ovt_active && !ovt_disabled);
      // [RL15] Formula select
      core_volt_formula_sel <= vcore_and_overtemp_config[VOVT_VSEL];
    end
  end
endmodule // afcc_top

// ===== tb/afcc_top_assertions.sv
// Port checker for the fan cruise block
module afcc_top_assertions
  import afcc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sensor and outputs
  input wire logic system_temp_over,
  input wire logic [7:0] system_fan_drive,
  input wire logic [7:0] aux_fan_drive,
  input wire logic overtemp_alert_out_n,
  input wire logic core_volt_formula_sel
);
  logic wr_en;
  logic [5:0] idx;
  logic [1:0] mode_sh;
  logic [7:0] lvl_sh, start_sh, stop_sh, cfg_sh;
  logic dis_sh, omode_sh, vsel_sh, cmp_on, rsvd;
  assign idx = paddr[7:2];
  assign wr_en = psel && penable && pwrite && pready && paddr[1:0] == 2'b00;
  assign dis_sh = cfg_sh[VOVT_OVT_DIS];
  assign omode_sh = cfg_sh[VOVT_OVT_MODE];
  assign vsel_sh = cfg_sh[VOVT_VSEL];
  assign cmp_on = !dis_sh && !omode_sh;
  assign rsvd = idx == IDX_RSVD_10 || idx == IDX_RSVD_19 || (idx >= IDX_RSVD_LO && idx <= IDX_RSVD_HI);
  // Shadows load with the block's registers; outputs lag them a cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sh <= 2'b00;
      lvl_sh <= RST_AUX_LEVEL;
      start_sh <= RST_AUX_START;
      stop_sh <= RST_AUX_STOP;
      cfg_sh <= RST_VOVT_CFG;
    end else if (wr_en) begin
      case (idx)
        IDX_FAN_CFG2: mode_sh <= pwdata[2:1];
        IDX_AUX_LEVEL: lvl_sh <= pwdata[7:0];
        IDX_AUX_START: start_sh <= pwdata[7:0];
        IDX_AUX_STOP: stop_sh <= pwdata[7:0];
        IDX_VOVT_CFG: cfg_sh <= pwdata[7:0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  rsvd_read_a: assert property (
    psel && !penable && !pwrite && rsvd |=> prdata == 32'h0 && !pslverr)
    else $error("reserved read not zero");
  manual_lvl_a: assert property (
    $past(presetn) && $past(mode_sh) == 2'b00
    |-> aux_fan_drive == {$past(lvl_sh[7:4]), 4'h0}) else $error("manual level wrong");
  alert_off_a: assert property (
    dis_sh && $past(dis_sh) |-> overtemp_alert_out_n) else $error("alert not silenced");
  compare_a: assert property (
    (cmp_on && system_temp_over) [*5] |-> !overtemp_alert_out_n) else $error("alert missing");
  latched_a: assert property (
    !dis_sh && omode_sh && !overtemp_alert_out_n && !wr_en && !$past(wr_en)
    |=> !overtemp_alert_out_n) else $error("latched alert lost");
  formula_a: assert property (
    $stable(vsel_sh) && $past(vsel_sh, 2) == vsel_sh |-> core_volt_formula_sel == vsel_sh)
    else $error("formula select wrong");
  sys_step_a: assert property (
    $changed(system_fan_drive) |->
    system_fan_drive - $past(system_fan_drive) inside {8'h01, 8'hff}) else $error("step not one");
  aux_start_a: assert property (
    mode_sh == 2'b01 && $past(mode_sh) == 2'b01 && $past(aux_fan_drive) == 8'h00 &&
    aux_fan_drive != 8'h00 |-> aux_fan_drive == start_sh) else $error("start value wrong");
  aux_floor_a: assert property (
    mode_sh == 2'b01 && aux_fan_drive < $past(aux_fan_drive) && aux_fan_drive != 8'h00
    |-> aux_fan_drive >= stop_sh) else $error("aux below stop value");
endmodule // afcc_top_assertions

bind afcc_top afcc_top_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .system_temp_over(system_temp_over), .system_fan_drive(system_fan_drive),
  .aux_fan_drive(aux_fan_drive), .overtemp_alert_out_n(overtemp_alert_out_n),
  .core_volt_formula_sel(core_volt_formula_sel)
);

// ===== tb/afcc_far_side.sv
// Fans and sensors beside the fan cruise block
module afcc_far_side (
  // Bench settings
  input wire logic [7:0] temp,
  input wire logic [4:0] cond,
  // Aux fan drive
  input wire logic [7:0] aux_fan_drive,
  // Sensor outputs
  output logic [7:0] aux_temp_input,
  output logic [7:0] aux_tach_input,
  output logic [4:0] flags
);
  timeunit 1ns;
  timeprecision 1ns;
  assign aux_temp_input = temp;
  assign flags = cond;
  // Tach follows the drive with a lag, off the clock edge as a real fan would
  assign #3 aux_tach_input = aux_fan_drive;
endmodule // afcc_far_side

// ===== tb/afcc_top_bench.sv
// Self-checking bench for the fan cruise block
module afcc_top_bench;
  import afcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] temp = 8'h00;
  // Flags: over, processor cold, processor hot, system cold, system hot
  logic [4:0] cond = 5'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, alert_n, vsel, irq;
  logic [7:0] tin, tach, c;
  logic [7:0] drv [3];
  logic [4:0] flg;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int k;
  logic [13:0] rt [15] = '{{IDX_STEP_UP, 8'h0a}, {IDX_AUX_LEVEL, 8'hff}, {IDX_FAN_CFG2, 8'h00},
    {IDX_AUX_TARGET, 8'h00}, {IDX_AUX_TOL, 8'h00}, {IDX_AUX_STOP, 8'h01},
    {IDX_AUX_START, 8'h01}, {IDX_AUX_STOP_TIME, 8'h3c}, {IDX_VOVT_CFG, 8'h43},
    {IDX_SCRATCH_A, 8'hff}, {IDX_SCRATCH_B, 8'hff}, {IDX_RSVD_10, 8'h00},
    {IDX_RSVD_19, 8'h00}, {IDX_RSVD_LO, 8'h00}, {IDX_RSVD_HI, 8'h00}};

  afcc_far_side u_far (.temp(temp), .cond(cond), .aux_fan_drive(drv[2]),
    .aux_temp_input(tin), .aux_tach_input(tach), .flags(flg));
  afcc_top #(.TICK_CYCLES(TK)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aux_temp_input(tin), .aux_tach_input(tach), .system_temp_hot(flg[0]),
    .system_temp_cold(flg[1]), .processor_temp_hot(flg[2]), .processor_temp_cold(flg[3]),
    .system_temp_over(flg[4]), .system_fan_drive(drv[0]), .processor_fan_drive(drv[1]),
    .aux_fan_drive(drv[2]), .overtemp_alert_out_n(alert_n), .core_volt_formula_sel(vsel),
    .irq(irq));

  always #5 pclk = ~pclk;

  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %b seen %b", n, e, g);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d,
                     input logic [1:0] lo = 2'b00);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, lo};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask

  task automatic rdc(input logic [5:0] i, input logic [7:0] e, input logic ee);
    apb(1'b0, i, 8'h00);
    chk_val("prdata", {24'h0, e}, rd);
    chk_bit("pslverr", ee, err);
  endtask

  task automatic wait_drv(input int s, input logic [7:0] e, input int lim);
    k = 0;
    while (drv[s] !== e && k < lim) begin
      @(posedge pclk);
      k++;
    end
    chk_val("drive", {24'h0, e}, {24'h0, drv[s]});
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int j = 0; j < 15; j++) begin
      rdc(rt[j][13:8], rt[j][7:0], 1'b0);
    end
    chk_bit("formula", 1'b1, vsel);
    wait_drv(2, 8'hf0, 4);
    wr(IDX_SCRATCH_A, 8'h5a);
    wr(IDX_RSVD_19, 8'h77);
    wr(IDX_AUX_LEVEL, 8'h3c);
    rdc(IDX_SCRATCH_A, 8'h5a, 1'b0);
    rdc(IDX_RSVD_19, 8'h00, 1'b0);
    apb(1'b0, IDX_SCRATCH_B, 8'h00, 2'b10);
    chk_bit("misaligned", 1'b1, err);
    wait_drv(2, 8'h30, 4);
    wr(IDX_AUX_LEVEL, 8'h0f);
    wait_drv(2, 8'h00, 4);
    cond <= 5'h10;
    repeat (6) @(posedge pclk);
    chk_bit("alert", 1'b1, alert_n);
    wr(IDX_VOVT_CFG, 8'h02);
    repeat (5) @(posedge pclk);
    chk_bit("alert", 1'b0, alert_n);
    chk_bit("formula", 1'b0, vsel);
    cond <= 5'h00;
    repeat (5) @(posedge pclk);
    chk_bit("alert", 1'b1, alert_n);
    wr(IDX_VOVT_CFG, 8'h12);
    cond <= 5'h10;
    repeat (5) @(posedge pclk);
    cond <= 5'h00;
    repeat (5) @(posedge pclk);
    chk_bit("alert", 1'b0, alert_n);
    wr(IDX_INT_STATUS, 8'h01);
    repeat (3) @(posedge pclk);
    chk_bit("alert", 1'b1, alert_n);
    wr(IDX_SYS_MIN, 8'h05);
    wr(IDX_STEP_UP, 8'h00);
    wr(IDX_STEP_DOWN, 8'h00);
    wr(IDX_FAN_CFG2, 8'h20);
    cond <= 5'h05;
    wait_drv(0, 8'h08, 250);
    cond <= 5'h0a;
    wait_drv(1, 8'h00, 250);
    wait_drv(0, 8'h05, 0);
    wr(IDX_STEP_UP, 8'h01);
    cond <= 5'h01;
    for (int p = 0; p < 2; p++) begin
      k = 0;
      c = drv[0];
      while (drv[0] === c && k < 400) begin
        @(posedge pclk);
        k++;
      end
    end
    chk_val("step", STEP_TICKS * TK, k);
    cond <= 5'h00;
    wr(IDX_STEP_UP, 8'h00);
    wr(IDX_AUX_STOP, 8'h10);
    wr(IDX_AUX_START, 8'h20);
    wr(IDX_AUX_STOP_TIME, 8'h02);
    wr(IDX_AUX_TARGET, 8'h28);
    wr(IDX_AUX_TOL, 8'h02);
    wr(IDX_INT_MASK, 8'h06);
    temp <= 8'h40;
    wr(IDX_FAN_CFG2, 8'h0a);
    wait_drv(2, 8'h20, 100);
    repeat (3) @(posedge pclk);
    chk_bit("irq", 1'b1, irq);
    rdc(IDX_INT_STATUS, 8'h02, 1'b0);
    wr(IDX_INT_STATUS, 8'h02);
    repeat (3) @(posedge pclk);
    chk_bit("irq", 1'b0, irq);
    wait_drv(2, 8'h23, 100);
    temp <= 8'h10;
    wait_drv(2, 8'h10, 500);
    repeat (100) @(posedge pclk);
    wait_drv(2, 8'h10, 0);
    wr(IDX_INT_MASK, 8'h00);
    wr(IDX_FAN_CFG2, 8'h02);
    wait_drv(2, 8'h00, 100);
    chk_bit("irq", 1'b0, irq);
    rdc(IDX_INT_STATUS, 8'h04, 1'b0);
    wr(IDX_INT_MASK, 8'h04);
    repeat (3) @(posedge pclk);
    chk_bit("irq", 1'b1, irq);
    wr(IDX_INT_STATUS, 8'h04);
    repeat (3) @(posedge pclk);
    chk_bit("irq", 1'b0, irq);
    wr(IDX_AUX_TARGET, 8'h40);
    wr(IDX_FAN_CFG2, 8'h04);
    wait_drv(2, 8'h3e, 800);
    repeat (60) @(posedge pclk);
    wait_drv(2, 8'h3e, 0);
    wr(IDX_FAN_CFG2, 8'h06);
    wr(IDX_AUX_TARGET, 8'h80);
    repeat (60) @(posedge pclk);
    wait_drv(2, 8'h3e, 0);
    wr(IDX_FAN_CFG2, 8'h00);
    wr(IDX_AUX_LEVEL, 8'ha5);
    wait_drv(2, 8'ha0, 4);
    stop_test();
  end
endmodule // afcc_top_bench
